// >>> common/coc_params.svh
`ifndef COC_PARAMS_SVH
`define COC_PARAMS_SVH

// =====================================================================
// Register map, byte addresses
// =====================================================================
`define COC_UNIT_BIT        4
`define COC_OFS_CR0         4'h4
`define COC_OFS_CR1         4'h8
`define COC_OFS_SR          4'hc

// =====================================================================
// Control register 0 fields
// =====================================================================
`define COC_CR0_EN          0
`define COC_CR0_HYS_LO      1
`define COC_CR0_HYS_HI      2
`define COC_CR0_SETTLE_TIME_SEL_LO     3
`define COC_CR0_SETTLE_TIME_SEL_HI     4
`define COC_CR0_IE          5
`define COC_CR0_POL         6
`define COC_CR0_WIN         7
`define COC_CR0_RST         16'h0000

// =====================================================================
// Control register 1 fields
// =====================================================================
`define COC_CR1_FILTER_ENABLE       0
`define COC_CR1_FILTER_CLOCK_SEL      1
`define COC_CR1_FLTW_LO     2
`define COC_CR1_FLTW_HI     4
`define COC_CR1_BLK_LO      5
`define COC_CR1_BLK_HI      7
`define COC_CR1_TRIG_LO     8
`define COC_CR1_TRIG_HI     10
`define COC_CR1_BRAKE       11
`define COC_CR1_REFCLR      12
`define COC_CR1_LVLIE       13
`define COC_CR1_RISE_IRQ_EN      14
`define COC_CR1_FALL_IRQ_EN      15
`define COC_CR1_RST         16'h0000

// =====================================================================
// Status register fields
// =====================================================================
`define COC_SR_LEVEL        0
`define COC_SR_FLAG         1
`define COC_SR_READY        2

// =====================================================================
// Timing
// =====================================================================
`define COC_CLK_NS          40
`define COC_RESP0_NS        200
`define COC_RESP1_NS        2000
`define COC_RESP2_NS        5000
`define COC_RESP3_NS        20000
`define COC_BLANK_BASE      10'h004

`endif

// >>> common/coc_pkg.sv
package coc_pkg;

   typedef enum logic [1:0] {
      COC_ST_OFF,
      COC_ST_SETTLE,
      COC_ST_READY
   } coc_ready_state_type;

   // Settings driven to one analog core
   typedef struct packed {
      logic       enable;
      logic [1:0] settle_time_sel;
      logic [1:0] deadband_sel;
   } coc_analog_cfg_type;

   // Conditioned results of one comparator unit
   typedef struct packed {
      logic comparator_pin_out;
      logic brake_input;
      logic reference_clear_input;
      logic irq_req;
   } coc_unit_out_type;

endpackage

// >>> design/coc_top.sv
`timescale 1ns/100ps
`include "coc_params.svh"

//Behaviour
//- Per-unit settle time select drives analog core
//- Invert set: output is inverted raw result
//- Invert clear: output follows raw result
//- Filter used when enabled, else bypassed
//- Filter ticks on bus clock or RC
//- Eight widths reject short pulses
//- Filtered level readable in status
//- Filtered level drives comparator pin output
//- Route output to brake and ref-clear
//- Two-bit hysteresis code to analog core
//- Window mode XORs both adjusted signals
//- Blanking holds output at present level
//- Blanking lasts 2^(n+2) to +2 cycles
//- Enabled timer channel rising edges start blanking
//- Enabled trigger sets flag and requests interrupt
//- Writing zero clears the interrupt flag
//- High level triggers when enabled
//- Rising edge triggers when enabled
//- Falling edge triggers when enabled
//- Interrupt drives wake request in low power
//- Ready flag set once output valid
//- Trigger selections combine freely
module coc_top (
   input  wire logic                                clk_sys,
   input  wire logic                                rst,
   input  wire logic [4:0]                          avs_address,
   input  wire logic                                avs_read,
   input  wire logic                                avs_write,
   input  wire logic [31:0]                         avs_writedata,
   input  wire logic [3:0]                          avs_byteenable,
   output logic [31:0]                              avs_readdata,
   output logic                                     avs_waitrequest,
   input  wire logic [1:0]                          raw_analog_result,
   input  wire logic                                rc_osc_clk,
   input  wire logic [2:0]                          timer_chb,
   output coc_pkg::coc_analog_cfg_type [1:0]        analog_cfg,
   output coc_pkg::coc_unit_out_type [1:0]          unit_out,
   output logic                                     wake_req
);

   // =====================================================================
   // Functions
   // =====================================================================
   function automatic logic addr_hit(input logic [4:0] addr, input logic unit, input logic [3:0] ofs);
      addr_hit = (addr[`COC_UNIT_BIT] == unit) && (addr[3:0] == ofs);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [15:0] wdata,
                                           input logic [1:0] be);
      merge16 = old_val;
      if (be[0]) begin
         merge16[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wdata[15:8];
      end
   endfunction

   function automatic logic [9:0] settle_cycles(input logic [1:0] sel);
      unique case (sel)
         2'h0: settle_cycles = 10'((`COC_RESP0_NS + `COC_CLK_NS - 1) / `COC_CLK_NS);
         2'h1: settle_cycles = 10'((`COC_RESP1_NS + `COC_CLK_NS - 1) / `COC_CLK_NS);
         2'h2: settle_cycles = 10'((`COC_RESP2_NS + `COC_CLK_NS - 1) / `COC_CLK_NS);
         2'h3: settle_cycles = 10'((`COC_RESP3_NS + `COC_CLK_NS - 1) / `COC_CLK_NS);
      endcase
   endfunction

   // Widths 1,2,4..128 filter ticks
   function automatic logic [7:0] filter_width(input logic [2:0] sel);
      filter_width = 8'h01 << sel;
   endfunction

   // =====================================================================
   // Input synchronisers
   // =====================================================================
   logic [1:0] raw_meta_reg;
   logic [1:0] raw_sync_reg;
   logic       rc_meta_reg;
   logic       rc_sync_reg;
   logic       rc_prev_reg;
   logic [2:0] chb_meta_reg;
   logic [2:0] chb_sync_reg;
   logic [2:0] chb_prev_reg;
   logic       rc_tick;
   logic [2:0] chb_rise;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         raw_meta_reg <= 2'h0;
         raw_sync_reg <= 2'h0;
      end else begin
         raw_meta_reg <= raw_analog_result;
         raw_sync_reg <= raw_meta_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rc_meta_reg <= 1'b0;
         rc_sync_reg <= 1'b0;
         rc_prev_reg <= 1'b0;
      end else begin
         rc_meta_reg <= rc_osc_clk;
         rc_sync_reg <= rc_meta_reg;
         rc_prev_reg <= rc_sync_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         chb_meta_reg <= 3'h0;
         chb_sync_reg <= 3'h0;
         chb_prev_reg <= 3'h0;
      end else begin
         chb_meta_reg <= timer_chb;
         chb_sync_reg <= chb_meta_reg;
         chb_prev_reg <= chb_sync_reg;
      end
   end

   // Slow RC clock becomes a one-cycle enable
   assign rc_tick  = rc_sync_reg & ~rc_prev_reg;
   assign chb_rise = chb_sync_reg & ~chb_prev_reg;

   // =====================================================================
   // Bus slave
   // =====================================================================
   logic        ack_reg;
   logic        wr_fire;
   logic [31:0] readdata_reg;
   logic [31:0] read_next;
   logic [15:0] cr0_reg [2];
   logic [15:0] cr1_reg [2];
   logic [1:0]  flag_reg;
   logic [1:0]  out_reg;
   logic [1:0]  ready_bit;

   // One wait state on every access
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_fire         = avs_write & ack_reg;

   always_comb begin
      read_next = 32'h0000_0000;
      for (int u = 0; u < 2; u++) begin
         if (addr_hit(avs_address, 1'(u), `COC_OFS_CR0)) begin
            read_next = {16'h0000, cr0_reg[u]};
         end
         if (addr_hit(avs_address, 1'(u), `COC_OFS_CR1)) begin
            read_next = {16'h0000, cr1_reg[u]};
         end
         if (addr_hit(avs_address, 1'(u), `COC_OFS_SR)) begin
            read_next[`COC_SR_LEVEL] = out_reg[u];
            read_next[`COC_SR_FLAG]  = flag_reg[u];
            read_next[`COC_SR_READY] = ready_bit[u];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (avs_read & ~ack_reg) begin
         readdata_reg <= read_next;
      end
   end

   assign avs_readdata = readdata_reg;
   assign wake_req     = |flag_reg;

   // =====================================================================
   // Comparator units
   // =====================================================================
   logic [1:0] pol_adj;

   for (genvar i = 0; i < 2; i++) begin : g_unit
      coc_pkg::coc_ready_state_type state_reg;
      logic [9:0] settle_cnt_reg;
      logic       win;
      logic       filt_reg;
      logic [7:0] filt_cnt_reg;
      logic       filt_tick;
      logic [9:0] blank_cnt_reg;
      logic       blank_act;
      logic       blank_trig;
      logic       prev_reg;
      logic       trig_event;
      logic       flag_clr;
      logic       cr0_wr;
      logic       cr1_wr;

      assign cr0_wr = wr_fire & addr_hit(avs_address, 1'(i), `COC_OFS_CR0);
      assign cr1_wr = wr_fire & addr_hit(avs_address, 1'(i), `COC_OFS_CR1);

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            cr0_reg[i] <= `COC_CR0_RST;
         end else if (cr0_wr) begin
            cr0_reg[i] <= merge16(cr0_reg[i], avs_writedata[15:0], avs_byteenable[1:0]);
         end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            cr1_reg[i] <= `COC_CR1_RST;
         end else if (cr1_wr) begin
            cr1_reg[i] <= merge16(cr1_reg[i], avs_writedata[15:0], avs_byteenable[1:0]);
         end
      end

      assign analog_cfg[i].enable          = cr0_reg[i][`COC_CR0_EN];
      assign analog_cfg[i].settle_time_sel = cr0_reg[i][`COC_CR0_SETTLE_TIME_SEL_HI:`COC_CR0_SETTLE_TIME_SEL_LO];
      assign analog_cfg[i].deadband_sel    = cr0_reg[i][`COC_CR0_HYS_HI:`COC_CR0_HYS_LO];

      // Ready after the selected settle time from enable
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            state_reg      <= coc_pkg::COC_ST_OFF;
            settle_cnt_reg <= 10'h000;
         end else if (!cr0_reg[i][`COC_CR0_EN]) begin
            state_reg      <= coc_pkg::COC_ST_OFF;
            settle_cnt_reg <= 10'h000;
         end else begin
            unique case (state_reg)
               coc_pkg::COC_ST_OFF: begin
                  state_reg      <= coc_pkg::COC_ST_SETTLE;
                  settle_cnt_reg <= settle_cycles(cr0_reg[i][`COC_CR0_SETTLE_TIME_SEL_HI:`COC_CR0_SETTLE_TIME_SEL_LO]);
               end
               coc_pkg::COC_ST_SETTLE: begin
                  if (settle_cnt_reg <= 10'h001) begin
                     state_reg <= coc_pkg::COC_ST_READY;
                  end
                  settle_cnt_reg <= settle_cnt_reg - 10'h001;
               end
               coc_pkg::COC_ST_READY: begin
                  state_reg <= coc_pkg::COC_ST_READY;
               end
               default: begin
                  state_reg <= coc_pkg::COC_ST_OFF;
               end
            endcase
         end
      end

      assign ready_bit[i] = (state_reg == coc_pkg::COC_ST_READY);

      // Polarity and window selection
      assign pol_adj[i] = raw_sync_reg[i] ^ cr0_reg[i][`COC_CR0_POL];
      assign win = cr0_reg[i][`COC_CR0_WIN] ? (pol_adj[0] ^ pol_adj[1]) : pol_adj[i];

      // Noise filter
      assign filt_tick = cr1_reg[i][`COC_CR1_FILTER_CLOCK_SEL] | rc_tick;

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            filt_reg     <= 1'b0;
            filt_cnt_reg <= 8'h00;
         end else if (win == filt_reg) begin
            filt_cnt_reg <= 8'h00;
         end else if (filt_tick) begin
            if (filt_cnt_reg + 8'h01 >= filter_width(cr1_reg[i][`COC_CR1_FLTW_HI:`COC_CR1_FLTW_LO])) begin
               filt_reg     <= win;
               filt_cnt_reg <= 8'h00;
            end else begin
               filt_cnt_reg <= filt_cnt_reg + 8'h01;
            end
         end
      end

      // Blanking window
      assign blank_trig = |(chb_rise & cr1_reg[i][`COC_CR1_TRIG_HI:`COC_CR1_TRIG_LO]);
      assign blank_act  = (blank_cnt_reg != 10'h000);

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            blank_cnt_reg <= 10'h000;
         end else if (blank_act) begin
            blank_cnt_reg <= blank_cnt_reg - 10'h001;
         end else if (blank_trig) begin
            blank_cnt_reg <= `COC_BLANK_BASE << cr1_reg[i][`COC_CR1_BLK_HI:`COC_CR1_BLK_LO];
         end
      end

      // Final conditioned output
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            out_reg[i] <= 1'b0;
         end else if (!cr0_reg[i][`COC_CR0_EN]) begin
            out_reg[i] <= 1'b0;
         end else if (!blank_act) begin
            out_reg[i] <= cr1_reg[i][`COC_CR1_FILTER_ENABLE] ? filt_reg : win;
         end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            prev_reg <= 1'b0;
         end else begin
            prev_reg <= out_reg[i];
         end
      end

      // Interrupt trigger
      assign trig_event = (cr1_reg[i][`COC_CR1_LVLIE] & out_reg[i])
                        | (cr1_reg[i][`COC_CR1_RISE_IRQ_EN] & out_reg[i] & ~prev_reg)
                        | (cr1_reg[i][`COC_CR1_FALL_IRQ_EN] & ~out_reg[i] & prev_reg);

      assign flag_clr = wr_fire & addr_hit(avs_address, 1'(i), `COC_OFS_SR) & avs_byteenable[0]
                        & ~avs_writedata[`COC_SR_FLAG];

      // Set beats a simultaneous clear
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            flag_reg[i] <= 1'b0;
         end else if (cr0_reg[i][`COC_CR0_IE] & trig_event) begin
            flag_reg[i] <= 1'b1;
         end else if (flag_clr) begin
            flag_reg[i] <= 1'b0;
         end
      end

      assign unit_out[i].comparator_pin_out    = out_reg[i];
      assign unit_out[i].brake_input           = out_reg[i] & cr1_reg[i][`COC_CR1_BRAKE];
      assign unit_out[i].reference_clear_input = out_reg[i] & cr1_reg[i][`COC_CR1_REFCLR];
      assign unit_out[i].irq_req               = flag_reg[i];
   end

endmodule

// >>> testbench/coc_top_asserts.sv
`timescale 1ns/100ps
module coc_top_asserts (
   input wire logic                              clk_sys,
   input wire logic                              rst,
   input wire logic [4:0]                        avs_address,
   input wire logic                              avs_read,
   input wire logic                              avs_write,
   input wire logic [31:0]                       avs_writedata,
   input wire logic [3:0]                        avs_byteenable,
   input wire logic [31:0]                       avs_readdata,
   input wire logic                              avs_waitrequest,
   input wire coc_pkg::coc_analog_cfg_type [1:0] analog_cfg,
   input wire coc_pkg::coc_unit_out_type [1:0]   unit_out,
   input wire logic                              wake_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic clr0_done;
   // Status write completing with a zero in the flag bit
   assign clr0_done = avs_write && !avs_waitrequest && avs_address == 5'h0c
                      && avs_byteenable[0] && !avs_writedata[1];
   AST_ONE_WAIT:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
         else $error("wait state longer than one cycle");
   AST_RD_UPPER_ZERO:
      assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
         else $error("upper read data not zero");
   AST_CFG_HOLD:
      assert property (!avs_write |=> $stable(analog_cfg))
         else $error("analog settings moved without a write");
   AST_BRAKE0:
      assert property (unit_out[0].brake_input |-> unit_out[0].comparator_pin_out)
         else $error("brake high while output low");
   AST_REFCLR1:
      assert property (unit_out[1].reference_clear_input |-> unit_out[1].comparator_pin_out)
         else $error("reference clear high while output low");
   AST_WAKE_OR:
      assert property (wake_req == (unit_out[0].irq_req || unit_out[1].irq_req))
         else $error("wake request does not follow flags");
   AST_FLAG_CLR:
      assert property ($fell(unit_out[0].irq_req) |-> $past(clr0_done))
         else $error("flag dropped without a zero write");
   AST_FLAG_HOLD:
      assert property (unit_out[0].irq_req && !clr0_done |=> unit_out[0].irq_req)
         else $error("flag lost while no clear");
   COV_IRQ: cover property ($rose(unit_out[0].irq_req));
   COV_BRAKE: cover property (unit_out[0].brake_input);
   COV_PIN_FALL: cover property ($fell(unit_out[0].comparator_pin_out));
endmodule

bind coc_top coc_top_asserts chk_u (
   .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .analog_cfg(analog_cfg),
   .unit_out(unit_out), .wake_req(wake_req)
);

// >>> testbench/coc_partner.sv
`timescale 1ns/100ps
module coc_partner (
   input wire logic        clk_sys,
   input wire logic        slow,
   input wire logic [1:0]  cmp_req,
   input wire logic [2:0]  chb_req,
   output logic [1:0]      raw_analog_result,
   output logic [2:0]      timer_chb,
   output logic            rc_osc_clk
);
   logic [1:0] cmp_dly = 2'h0;
   initial raw_analog_result = 2'h0;
   initial timer_chb = 3'h0;
   // Free running slow oscillator, about 150 kHz
   initial begin
      rc_osc_clk = 1'b0;
      forever #3333 rc_osc_clk = ~rc_osc_clk;
   end
   // Comparator result, high when positive input wins; slow adds settling
   always @(posedge clk_sys) begin
      cmp_dly <= cmp_req;
      raw_analog_result <= slow ? cmp_dly : cmp_req;
   end
   always @(posedge clk_sys) begin
      timer_chb <= chb_req;
   end
endmodule

// >>> testbench/comparator_output_conditioner_test.sv
`timescale 1ns/100ps
`include "coc_params.svh"
module comparator_output_conditioner_test;
   logic                               clk_sys, rst, avs_read, avs_write, slow, rc_osc_clk, wake_req;
   logic                               avs_waitrequest;
   logic [4:0]                         avs_address;
   logic [31:0]                        avs_writedata, avs_readdata;
   logic [3:0]                         avs_byteenable;
   logic [1:0]                         cmp_req, raw_analog_result;
   logic [2:0]                         chb_req, timer_chb;
   coc_pkg::coc_analog_cfg_type [1:0]  analog_cfg;
   coc_pkg::coc_unit_out_type [1:0]    unit_out;
   int                                 num_errors, num_checks, cycles, n;
   int                                 settle_time_sel_ns[4] = '{`COC_RESP0_NS, `COC_RESP1_NS, `COC_RESP2_NS, `COC_RESP3_NS};

   coc_top dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .raw_analog_result(raw_analog_result), .rc_osc_clk(rc_osc_clk), .timer_chb(timer_chb),
      .analog_cfg(analog_cfg), .unit_out(unit_out), .wake_req(wake_req));
   coc_partner far_u (.clk_sys(clk_sys), .slow(slow), .cmp_req(cmp_req), .chb_req(chb_req),
      .raw_analog_result(raw_analog_result), .timer_chb(timer_chb), .rc_osc_clk(rc_osc_clk));

   // ====================
   // Helpers
   // ====================
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("CHECK FAILED t=%0t timeout", $time);
         print_verdict;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic pin_chk(input int u, input logic exp);
      @(negedge clk_sys);
      chk({31'h0, unit_out[u].comparator_pin_out}, {31'h0, exp});
   endtask
   task automatic irq_chk(input logic exp);
      @(negedge clk_sys);
      chk({30'h0, wake_req, unit_out[0].irq_req}, {30'h0, exp, exp});
   endtask

   // ====================
   // Tests
   // ====================
   initial begin
      rst = 1'b1;
      {avs_read, avs_write, slow} = 3'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      cmp_req = 2'h0;
      chb_req = 3'h0;
      cyc(3);
      rst <= 1'b0;
      rd_chk(5'h04, 32'h0);
      rd_chk(5'h08, 32'h0);
      rd_chk(5'h0c, 32'h0);
      wr(5'h00, 16'hffff);
      rd_chk(5'h00, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(5'h04, 16'h0000);
         wr(5'h04, 16'(i * 8 + i * 2 + 1));
         @(negedge clk_sys);
         chk({28'h0, analog_cfg[0].settle_time_sel, analog_cfg[0].deadband_sel}, 32'(i * 5));
         rd_chk(5'h0c, 32'h0);
         cyc(1 + (settle_time_sel_ns[i] + 39) / 40);
         rd_chk(5'h0c, 32'h4);
      end
      $display("test settle done");
      wr(5'h04, 16'h0001);
      cmp_req <= 2'b01;
      cyc(4);
      pin_chk(0, 1'b1);
      rd_chk(5'h0c, 32'h5);
      wr(5'h04, 16'h0041);
      cyc(4);
      pin_chk(0, 1'b0);
      rd_chk(5'h0c, 32'h4);
      wr(5'h14, 16'h0001);
      wr(5'h04, 16'h0081);
      cmp_req <= 2'b11;
      cyc(4);
      pin_chk(0, 1'b0);
      cmp_req <= 2'b01;
      cyc(4);
      pin_chk(0, 1'b1);
      $display("test polarity done");
      wr(5'h04, 16'h0001);
      wr(5'h08, 16'h0800);
      wr(5'h18, 16'h1000);
      cmp_req <= 2'b11;
      cyc(4);
      @(negedge clk_sys);
      chk({25'h0, unit_out[0].brake_input, unit_out[0].reference_clear_input,
           unit_out[1].reference_clear_input, unit_out[1].brake_input, analog_cfg[1].enable,
           unit_out[1].comparator_pin_out, unit_out[1].irq_req}, 32'h56);
      $display("test routing done");
      wr(5'h08, 16'h000b);
      cyc(6);
      cmp_req <= 2'b10;
      cyc(3);
      cmp_req <= 2'b11;
      cyc(1);
      pin_chk(0, 1'b1);
      cyc(6);
      pin_chk(0, 1'b1);
      cmp_req <= 2'b10;
      cyc(10);
      pin_chk(0, 1'b0);
      wr(5'h08, 16'h0005);
      cmp_req <= 2'b11;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (unit_out[0].comparator_pin_out !== 1'b1 && n < 400);
      chk({31'h0, n > 100 && n < 400}, 32'h1);
      $display("test filter done");
      wr(5'h08, 16'h0120);
      chb_req <= 3'b001;
      cyc(3);
      cmp_req <= 2'b10;
      cyc(4);
      pin_chk(0, 1'b1);
      chb_req <= 3'b000;
      cyc(5);
      pin_chk(0, 1'b1);
      cyc(1);
      pin_chk(0, 1'b0);
      chb_req <= 3'b010;
      cyc(2);
      cmp_req <= 2'b11;
      cyc(5);
      pin_chk(0, 1'b1);
      chb_req <= 3'b000;
      $display("test blanking done");
      slow <= 1'b1;
      wr(5'h08, 16'h0000);
      cmp_req <= 2'b00;
      wr(5'h04, 16'h0021);
      for (int m = 0; m < 3; m++) begin
         wr(5'h08, 16'h2000 << m);
         wr(5'h0c, 16'h0000);
         cmp_req <= 2'b01;
         cyc(6);
         irq_chk(m != 2);
         cmp_req <= 2'b00;
         cyc(6);
         irq_chk(1'b1);
         wr(5'h0c, 16'h0000);
         irq_chk(1'b0);
      end
      wr(5'h08, 16'he000);
      cmp_req <= 2'b01;
      cyc(5);
      rd_chk(5'h0c, 32'h7);
      wr(5'h0c, 16'h0000);
      cyc(2);
      irq_chk(1'b1);
      wr(5'h04, 16'h0001);
      cmp_req <= 2'b00;
      wr(5'h0c, 16'h0000);
      cmp_req <= 2'b01;
      cyc(6);
      irq_chk(1'b0);
      $display("test interrupt done");
      print_verdict;
   end
endmodule
